/* qie_top.sv */
// quadrature decoder interrupt enable and request block
// assumes decoder conditions arrive on clk_i as pulses or levels,
// software reaches the registers over classic wishbone
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps

module qie_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [qie_pkg::QIE_ADR_W-1:0] wb_adr_i,
	input wire logic [qie_pkg::QIE_SEL_W-1:0] wb_sel_i,
	input wire logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_i,
	output logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sample_done_i,
	input wire logic report_period_done_i,
	input wire logic motion_sum_nonzero_i,
	input wire logic double_transition_sum_nonzero_i,
	input wire logic motion_sum_overflow_i,
	input wire logic double_transition_sum_overflow_i,
	input wire logic stopped_i,
	output logic [qie_pkg::QIE_NUM_EVT-1:0] int_enable_o,
	output logic irq_o
);
	import qie_pkg::*;

	typedef struct packed {
		logic [QIE_NUM_EVT-1:0] enable;
		logic [QIE_NUM_EVT-1:0] status;
		logic irq;
	} qie_top_state_type;

	qie_top_state_type state_r;
	qie_top_state_type state_nxt;
	logic [QIE_NUM_EVT-1:0] evt;
	logic [QIE_NUM_EVT-1:0] wr_ones;
	qie_reg_sel_type wr_sel;
	qie_reg_sel_type rd_sel;

	qie_reg_if reg_bus ();

	// maps a byte address onto one register, unmapped gives none
	function automatic qie_reg_sel_type qie_decode(input logic [11:0] adr);
		qie_reg_sel_type sel;
		sel = QIE_REG_NONE;
		case (adr[11:2])
			QIE_OFS_EVENT_STATUS[11:2]: begin
				sel = QIE_REG_STATUS;
			end
			QIE_OFS_INT_ENABLE_SET[11:2]: begin
				sel = QIE_REG_EN_SET;
			end
			QIE_OFS_INT_ENABLE_CLEAR[11:2]: begin
				sel = QIE_REG_EN_CLR;
			end
			QIE_OFS_INT_PENDING[11:2]: begin
				sel = QIE_REG_PENDING;
			end
			default: begin
				sel = QIE_REG_NONE;
			end
		endcase
		return sel;
	endfunction

	// zero-extends a five bit field into a bus word
	function automatic logic [31:0] qie_word(input logic [QIE_NUM_EVT-1:0] f);
		return {{(32 - QIE_NUM_EVT){1'b0}}, f};
	endfunction

	qie_wb_slave u_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.reg_bus(reg_bus.bus)
	);

	qie_evt_gen u_evt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sample_done_i(sample_done_i),
		.report_period_done_i(report_period_done_i),
		.motion_sum_nonzero_i(motion_sum_nonzero_i),
		.double_transition_sum_nonzero_i(double_transition_sum_nonzero_i),
		.motion_sum_overflow_i(motion_sum_overflow_i),
		.double_transition_sum_overflow_i(double_transition_sum_overflow_i),
		.stopped_i(stopped_i),
		.evt_o(evt)
	);

	assign wr_sel = qie_decode(reg_bus.addr);
	assign rd_sel = qie_decode(reg_bus.addr);

	// all fields live in byte lane 0, other lanes cannot touch them
	assign wr_ones = (reg_bus.wr && reg_bus.sel[0]) ?
		reg_bus.wdata[QIE_NUM_EVT-1:0] : '0;

	// read mux; unmapped and reserved bits answer zero
	always_comb begin
		case (rd_sel)
			QIE_REG_STATUS: begin
				reg_bus.rdata = qie_word(state_r.status);
			end
			QIE_REG_EN_SET, QIE_REG_EN_CLR: begin
				reg_bus.rdata = qie_word(state_r.enable);
			end
			QIE_REG_PENDING: begin
				reg_bus.rdata = qie_word(state_r.status & state_r.enable);
			end
			default: begin
				reg_bus.rdata = QIE_RST_DATA;
			end
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		// only ones act, so a zero write leaves every bit alone
		if (wr_sel == QIE_REG_EN_SET) begin
			state_nxt.enable = state_r.enable | wr_ones;
		end
		if (wr_sel == QIE_REG_EN_CLR) begin
			state_nxt.enable = state_r.enable & ~wr_ones;
		end
		// a new event beats a clear written in the same cycle
		if (wr_sel == QIE_REG_STATUS) begin
			state_nxt.status = (state_r.status & ~wr_ones) | evt;
		end else begin
			state_nxt.status = state_r.status | evt;
		end
		// irq follows the registered flags and enables, one cycle late
		state_nxt.irq = |(state_r.status & state_r.enable);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= '{enable: QIE_RST_ENABLE, status: QIE_RST_STATUS, irq: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign int_enable_o = state_r.enable;
	assign irq_o = state_r.irq;
endmodule

/* qie_pkg.sv */
// constants of the quadrature interrupt enable block
// assumes a 32-bit classic wishbone slave, byte addresses
package qie_pkg;
	localparam int QIE_ADR_W = 12;
	localparam int QIE_DAT_W = 32;
	localparam int QIE_SEL_W = 4;
	localparam int QIE_NUM_EVT = 5;

	// register byte offsets
	localparam logic [11:0] QIE_OFS_EVENT_STATUS = 12'h300;
	localparam logic [11:0] QIE_OFS_INT_ENABLE_SET = 12'h304;
	localparam logic [11:0] QIE_OFS_INT_ENABLE_CLEAR = 12'h308;
	localparam logic [11:0] QIE_OFS_INT_PENDING = 12'h30c;

	// event bit positions, shared by status, enable and pending
	localparam int QIE_BIT_SAMPLE_DONE = 0;
	localparam int QIE_BIT_REPORT_DONE = 1;
	localparam int QIE_BIT_SUM_OVERFLOW = 2;
	localparam int QIE_BIT_DOUBLE_TRANSITION = 3;
	localparam int QIE_BIT_STOPPED = 4;

	// values after reset
	localparam logic [4:0] QIE_RST_ENABLE = 5'h00;
	localparam logic [4:0] QIE_RST_STATUS = 5'h00;
	localparam logic [31:0] QIE_RST_DATA = 32'h0000_0000;

	// register selector decoded from the address
	typedef enum logic [4:0] {
		QIE_REG_NONE = 5'b00001,
		QIE_REG_STATUS = 5'b00010,
		QIE_REG_EN_SET = 5'b00100,
		QIE_REG_EN_CLR = 5'b01000,
		QIE_REG_PENDING = 5'b10000
	} qie_reg_sel_type;
endpackage

/* qie_reg_if.sv */
// register access strobes between bus slave and register file
// assumes one clock domain; wr is a one-cycle pulse
`timescale 1ns/1ps
interface qie_reg_if;
	logic wr;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [3:0] sel;
	logic [31:0] rdata;

	modport bus (
		output wr,
		output addr,
		output wdata,
		output sel,
		input rdata
	);

	modport regs (
		input wr,
		input addr,
		input wdata,
		input sel,
		output rdata
	);
endinterface

/* qie_wb_slave.sv */
// classic wishbone slave front end
// assumes master holds request until ack; one wait state answer
`timescale 1ns/1ps
module qie_wb_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [qie_pkg::QIE_ADR_W-1:0] wb_adr_i,
	input wire logic [qie_pkg::QIE_SEL_W-1:0] wb_sel_i,
	input wire logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_i,
	output logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	qie_reg_if.bus reg_bus
);
	import qie_pkg::*;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} qie_slv_state_type;

	qie_slv_state_type state_r;
	qie_slv_state_type state_nxt;
	logic req;

	// ack gated by its own state so it drops the cycle after it rose
	assign req = wb_cyc_i && wb_stb_i && !state_r.ack;

	assign reg_bus.wr = req && wb_we_i;
	assign reg_bus.addr = wb_adr_i;
	assign reg_bus.wdata = wb_dat_i;
	assign reg_bus.sel = wb_sel_i;

	always_comb begin
		state_nxt = state_r;
		state_nxt.ack = req;
		if (req && !wb_we_i) begin
			state_nxt.dat = reg_bus.rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= '{ack: 1'b0, dat: QIE_RST_DATA};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign wb_ack_o = state_r.ack;
	assign wb_dat_o = state_r.dat;
endmodule

/* qie_evt_gen.sv */
// registers decoder conditions into event bits, one cycle after the inputs
// assumes all inputs come from logic on clk_i
`timescale 1ns/1ps
module qie_evt_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sample_done_i,
	input wire logic report_period_done_i,
	input wire logic motion_sum_nonzero_i,
	input wire logic double_transition_sum_nonzero_i,
	input wire logic motion_sum_overflow_i,
	input wire logic double_transition_sum_overflow_i,
	input wire logic stopped_i,
	output logic [qie_pkg::QIE_NUM_EVT-1:0] evt_o
);
	import qie_pkg::*;

	typedef struct packed {
		logic [QIE_NUM_EVT-1:0] evt;
	} qie_evt_state_type;

	qie_evt_state_type state_r;
	qie_evt_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.evt = '0;
		state_nxt.evt[QIE_BIT_SAMPLE_DONE] = sample_done_i;
		// no motion since the last clear means no report
		state_nxt.evt[QIE_BIT_REPORT_DONE] =
			report_period_done_i && motion_sum_nonzero_i;
		state_nxt.evt[QIE_BIT_SUM_OVERFLOW] =
			motion_sum_overflow_i || double_transition_sum_overflow_i;
		state_nxt.evt[QIE_BIT_DOUBLE_TRANSITION] =
			report_period_done_i && double_transition_sum_nonzero_i;
		state_nxt.evt[QIE_BIT_STOPPED] = stopped_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= '{evt: QIE_RST_STATUS};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign evt_o = state_r.evt;
endmodule

/* qie_top_assertions.sv */
// assertions for the quadrature interrupt enable block
// assumes one clock, bound onto qie_top, ports watched by name
`timescale 1ns/1ps
module qie_top_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [qie_pkg::QIE_ADR_W-1:0] wb_adr_i,
	input wire logic [qie_pkg::QIE_SEL_W-1:0] wb_sel_i,
	input wire logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_i,
	input wire logic [qie_pkg::QIE_DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic report_period_done_i,
	input wire logic motion_sum_nonzero_i,
	input wire logic double_transition_sum_overflow_i,
	input wire logic [qie_pkg::QIE_NUM_EVT-1:0] int_enable_o,
	input wire logic irq_o
);
	import qie_pkg::*;
	logic tk, wr, hs, hc;
	logic [4:0] en, d;
	assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = tk & wb_we_i & wb_sel_i[0];
	assign hs = wr & (wb_adr_i[11:2] == QIE_OFS_INT_ENABLE_SET[11:2]);
	assign hc = wr & (wb_adr_i[11:2] == QIE_OFS_INT_ENABLE_CLEAR[11:2]);
	assign en = int_enable_o;
	assign d = wb_dat_i[4:0];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_rd;
		tk & ~wb_we_i & (wb_adr_i[11:2] == QIE_OFS_INT_ENABLE_SET[11:2])
			|=> wb_dat_o == {27'h0, $past(en)};
	endproperty
	a_rd: assert property (p_rd) else $error("enable read wrong");
	property p_set0;
		hs & d[0] |=> en[0];
	endproperty
	a_set0: assert property (p_set0) else $error("bit0 not set");
	property p_clr0;
		hc & d[0] |=> !en[0];
	endproperty
	a_clr0: assert property (p_clr0) else $error("bit0 not cleared");
	property p_set;
		hs |=> en == ($past(en) | $past(d));
	endproperty
	a_set: assert property (p_set) else $error("set write wrong");
	property p_clr;
		hc |=> en == ($past(en) & ~$past(d));
	endproperty
	a_clr: assert property (p_clr) else $error("clear write wrong");
	property p_bit4;
		(hs | hc) & d[4] |=> en[4] == $past(hs);
	endproperty
	a_bit4: assert property (p_bit4) else $error("stopped enable wrong");
	property p_clr32;
		hc & (d[3] | d[2]) |=> !(|(en[3:2] & $past(d[3:2])));
	endproperty
	a_clr32: assert property (p_clr32) else $error("bits 3,2 not cleared");
	property p_rep;
		report_period_done_i & motion_sum_nonzero_i ##2 en[1] |=> irq_o;
	endproperty
	a_rep: assert property (p_rep) else $error("report irq missing");
	property p_ovf;
		double_transition_sum_overflow_i ##2 en[2] |=> irq_o;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow irq missing");
	property p_off;
		en == 5'h00 |=> !irq_o;
	endproperty
	a_off: assert property (p_off) else $error("irq without enable");
	c_irq: cover property (irq_o);
	c_set: cover property (hs);
	c_clr: cover property (hc);
endmodule
bind qie_top qie_top_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.report_period_done_i(report_period_done_i), .motion_sum_nonzero_i(motion_sum_nonzero_i),
	.double_transition_sum_overflow_i(double_transition_sum_overflow_i),
	.int_enable_o(int_enable_o), .irq_o(irq_o));

/* qie_top_tb.sv */
// self-checking bench for the quadrature interrupt enable block
// assumes qie_top answers each wishbone request with ack
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", nm, e, s); end end
module qie_top_tb;
	import qie_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
	logic [6:0] evs = 7'h00;
	logic [4:0] en;
	int fail_count = 0, check_count = 0, cyc_n = 0;
	int bm[7] = '{0, 1, 2, 3, 4, 2, 0};
	// input patterns: sample, report, overflow, double, stopped, other overflow, period only
	logic [6:0] ev_tab[7] = '{7'h01, 7'h06, 7'h10, 7'h0a, 7'h40, 7'h20, 7'h02};
	qie_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.sample_done_i(evs[0]), .report_period_done_i(evs[1]), .motion_sum_nonzero_i(evs[2]),
		.double_transition_sum_nonzero_i(evs[3]), .motion_sum_overflow_i(evs[4]),
		.double_transition_sum_overflow_i(evs[5]), .stopped_i(evs[6]), .int_enable_o(en),
		.irq_o(irq));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		`CHK("rdata", e, rd)
	endtask
	// pulse lasts one cycle; irq lands two edges after it
	task automatic fire(input int i);
		@(posedge clk_i);
		evs <= ev_tab[i];
		@(posedge clk_i);
		evs <= 7'h00;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			fail_count++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(QIE_OFS_INT_ENABLE_SET, 32'h0);
		rdc(QIE_OFS_INT_ENABLE_CLEAR, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, QIE_OFS_INT_ENABLE_SET, 32'h1 << i);
			rdc(QIE_OFS_INT_ENABLE_CLEAR, (32'h2 << i) - 1);
		end
		wb(1'b1, QIE_OFS_INT_ENABLE_SET, 32'h0);
		wb(1'b1, QIE_OFS_INT_ENABLE_CLEAR, 32'h0);
		wb(1'b1, 12'h400, 32'h1f);
		rdc(12'h400, 32'h0);
		rdc(QIE_OFS_INT_ENABLE_SET, 32'h1f);
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, QIE_OFS_INT_ENABLE_CLEAR, 32'h1 << i);
			`CHK("enable", 5'h1f << (i + 1), en)
		end
		$display("test enable bits done");
		for (int i = 0; i < 6; i++) begin
			wb(1'b1, QIE_OFS_INT_ENABLE_SET, 32'h1 << bm[i]);
			wb(1'b1, QIE_OFS_EVENT_STATUS, 32'h1f);
			fire(i);
			`CHK("irq", 1'b1, irq)
			rdc(QIE_OFS_INT_PENDING, 32'h1 << bm[i]);
			rdc(QIE_OFS_EVENT_STATUS, 32'h1 << bm[i]);
			wb(1'b1, QIE_OFS_INT_ENABLE_CLEAR, 32'h1f);
			`CHK("irq off", 1'b0, irq)
		end
		wb(1'b1, QIE_OFS_INT_ENABLE_SET, 32'h1f);
		wb(1'b1, QIE_OFS_EVENT_STATUS, 32'h1f);
		fire(6);
		`CHK("no motion irq", 1'b0, irq)
		$display("test events done");
		complete_run();
	end
endmodule
